/* rpc_pkg.sv */
// Package: register map, field positions and carriers for the regulator control block
package rpc_pkg;

	// Register index as printed; byte address is four times it
	localparam logic [7:0]  RPC_CTRL_INDEX   = 8'hc9;
	localparam logic [11:0] RPC_CTRL_ADDR    = {2'h0, RPC_CTRL_INDEX, 2'h0};
	// Interrupt registers placed just after the control word
	localparam logic [11:0] RPC_IRQ_STAT_ADDR = 12'h328;
	localparam logic [11:0] RPC_IRQ_MASK_ADDR = 12'h32c;
	localparam logic [11:0] RPC_STATE_ADDR    = 12'h330;

	// Control register field positions
	localparam int RPC_IO_DIS_BIT    = 7;
	localparam int RPC_WAKE_LVL_BIT  = 6;
	localparam int RPC_RSVD5_BIT     = 5;
	localparam int RPC_IO_LP_BIT     = 4;
	localparam int RPC_HALT_PD_BIT   = 3;
	localparam int RPC_RSVD2_BIT     = 2;
	localparam int RPC_CORE_LP_BIT   = 1;
	localparam int RPC_RSVD0_BIT     = 0;
	// Writable bits of the control register (all but the wake level)
	localparam logic [7:0] RPC_CTRL_WMASK = 8'hbf;
	localparam logic [7:0] RPC_CTRL_RESET = 8'h00;

	// Interrupt status/mask field positions
	localparam int RPC_EV_RISE_BIT = 0;
	localparam int RPC_EV_FALL_BIT = 1;
	localparam int RPC_EV_WIDTH    = 2;
	localparam logic [RPC_EV_WIDTH-1:0] RPC_EV_RESET = 2'h0;

	// AHB-Lite encodings
	localparam logic [1:0] RPC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] RPC_HTRANS_SEQ    = 2'h3;

	// Outputs towards the analog regulators and power controller
	typedef struct packed {
		logic io_regulator_enable;
		logic io_regulator_lowpower;
		logic core_regulator_lowpower;
		logic core_regulator_shutdown;
		logic power_net_shutdown;
		logic soft_reset_out;
	} rpc_power_t;

	// Reset requests arriving from the device's reset sources
	typedef struct packed {
		logic pin_reset;
		logic power_cycle;
		logic other_sources;
	} rpc_reset_req_t;

endpackage

/* rpc_wake_sync.sv */
// Wake pin synchroniser and both-edge detector
`timescale 1ns/100ps
`default_nettype none
module rpc_wake_sync
	import rpc_pkg::*;
#(
	parameter int STAGES = 2
) (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic [STAGES-1:0] sync;
		logic              last;
	} rpc_sync_state_t;

	rpc_sync_state_t state_reg;
	rpc_sync_state_t state_next;

	// First stage only feeds the next stage
	always_comb begin
		state_next      = state_reg;
		state_next.sync = {state_reg.sync[STAGES-2:0], pin_in};
		state_next.last = state_reg.sync[STAGES-1];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level = state_reg.sync[STAGES-1];
	assign rise  = state_reg.sync[STAGES-1] & ~state_reg.last;
	assign fall  = ~state_reg.sync[STAGES-1] & state_reg.last;
endmodule
`default_nettype wire

/* rpc_regulator_ctrl.sv */
// Regulator control, halt power-down and edge wake interrupt with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module rpc_regulator_ctrl
	import rpc_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            nrst,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic [31:0]          hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire logic            wake_pin,
	input  wire logic            edge_wake_enable,
	input  wire logic            halt_request,
	input  wire rpc_reset_req_t  reset_req,
	output rpc_power_t           power,
	output logic                 halted,
	output logic                 edge_wake_interrupt,
	output logic                 irq
);
	typedef struct packed {
		logic [7:0]              ctrl;
		logic [RPC_EV_WIDTH-1:0] ev_stat;
		logic [RPC_EV_WIDTH-1:0] ev_mask;
		logic                    halted;
		logic                    wake_pulse;
		logic                    soft_reset;
		logic                    dp_write;
		logic [11:0]             dp_addr;
		logic [31:0]             rdata;
	} rpc_state_t;

	rpc_state_t state_reg;
	rpc_state_t state_next;

	logic wake_level;
	logic wake_rise;
	logic wake_fall;

	rpc_wake_sync #(
		.STAGES (2)
	) u_wake_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.pin_in   (wake_pin),
		.level    (wake_level),
		.rise     (wake_rise),
		.fall     (wake_fall)
	);

	// Read view of the control word with the live pin level merged in
	function automatic logic [7:0] ctrl_view(input logic [7:0] c, input logic lvl);
		logic [7:0] v;
		v                   = c;
		v[RPC_WAKE_LVL_BIT] = lvl;
		return v;
	endfunction

	logic        addr_ok;
	logic [11:0] a_addr;
	logic        a_valid;
	logic [7:0]  wbyte;
	logic        rst_any;

	always_comb begin
		a_addr  = haddr[11:0];
		a_valid = hsel & hready & (htrans == RPC_HTRANS_NONSEQ || htrans == RPC_HTRANS_SEQ);
		wbyte   = hwdata[7:0];
		addr_ok = 1'b0;
		// While halt power-down is set, halted or not, only the pin or a power cycle may reset
		if (state_reg.ctrl[RPC_HALT_PD_BIT] && state_reg.halted) begin
			rst_any = reset_req.pin_reset | reset_req.power_cycle;
		end else if (state_reg.ctrl[RPC_HALT_PD_BIT]) begin
			rst_any = reset_req.pin_reset | reset_req.power_cycle;
		end else begin
			rst_any = reset_req.pin_reset | reset_req.power_cycle
				| reset_req.other_sources;
		end

		state_next            = state_reg;
		state_next.wake_pulse = edge_wake_enable & (wake_rise | wake_fall);

		// Data phase of a previous write
		if (state_reg.dp_write) begin
			unique case (state_reg.dp_addr)
				RPC_CTRL_ADDR: begin
					state_next.ctrl = wbyte & RPC_CTRL_WMASK;
				end
				RPC_IRQ_MASK_ADDR: begin
					state_next.ev_mask = wbyte[RPC_EV_WIDTH-1:0];
				end
				RPC_IRQ_STAT_ADDR: begin
					state_next.ev_stat = state_reg.ev_stat & ~wbyte[RPC_EV_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end
		// Set after clear so a same-cycle edge is kept
		if (edge_wake_enable && wake_rise) begin
			state_next.ev_stat[RPC_EV_RISE_BIT] = 1'b1;
		end
		if (edge_wake_enable && wake_fall) begin
			state_next.ev_stat[RPC_EV_FALL_BIT] = 1'b1;
		end

		// Address phase: capture and prepare read data one cycle ahead
		state_next.dp_write = 1'b0;
		state_next.rdata    = '0;
		if (a_valid) begin
			state_next.dp_write = hwrite;
			state_next.dp_addr  = a_addr;
			unique case (a_addr)
				RPC_CTRL_ADDR: begin
					addr_ok          = 1'b1;
					state_next.rdata = {24'h0, ctrl_view(state_reg.ctrl, wake_level)};
				end
				RPC_IRQ_STAT_ADDR: begin
					addr_ok          = 1'b1;
					state_next.rdata = {30'h0, state_reg.ev_stat};
				end
				RPC_IRQ_MASK_ADDR: begin
					addr_ok          = 1'b1;
					state_next.rdata = {30'h0, state_reg.ev_mask};
				end
				RPC_STATE_ADDR: begin
					addr_ok          = 1'b1;
					state_next.rdata = {31'h0, state_reg.halted};
				end
				default: begin
					addr_ok = 1'b0;
				end
			endcase
			// Read data only for reads; a write's data phase shows zero
			if (hwrite) begin
				state_next.rdata = '0;
			end
		end

		// Halt entry and exit; a reset always releases it
		if (halt_request) begin
			state_next.halted = 1'b1;
		end
		if (rst_any || (edge_wake_enable && (wake_rise || wake_fall))) begin
			state_next.halted = 1'b0;
		end
		state_next.soft_reset = rst_any;
		if (rst_any) begin
			state_next.ctrl    = RPC_CTRL_RESET;
			state_next.ev_stat = RPC_EV_RESET;
			state_next.ev_mask = RPC_EV_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = state_reg.rdata;

	always_comb begin
		power.io_regulator_enable     = ~state_reg.ctrl[RPC_IO_DIS_BIT];
		power.io_regulator_lowpower   = state_reg.ctrl[RPC_IO_LP_BIT];
		power.core_regulator_lowpower = state_reg.ctrl[RPC_CORE_LP_BIT];
		power.core_regulator_shutdown = state_reg.ctrl[RPC_HALT_PD_BIT]
			& state_reg.halted;
		power.power_net_shutdown      = state_reg.ctrl[RPC_HALT_PD_BIT]
			& state_reg.halted;
		power.soft_reset_out          = state_reg.soft_reset;
	end

	assign halted              = state_reg.halted;
	assign edge_wake_interrupt = state_reg.wake_pulse;
	assign irq                 = |(state_reg.ev_stat & state_reg.ev_mask);
	// Unused address bits and size ignored: word accesses only
	logic unused_ok;
	assign unused_ok = addr_ok ^ (|haddr[31:12]) ^ (|hsize) ^ (|hwdata[31:8]);
endmodule
`default_nettype wire

/* rpc_wake_src.sv */
// Wake pin source model driving the edge wake input
`timescale 1ns/100ps
`default_nettype none
module rpc_wake_src (
	input  wire logic level_req,
	output var logic  wake_pin
);
	// Off-grid skew keeps pin edges asynchronous to core_clk
	always @(level_req) wake_pin <= #1.7 level_req;
	initial wake_pin = 1'b0;
endmodule
`default_nettype wire

/* rpc_regulator_ctrl_asserts.sv */
// Port checker for the regulator control block
`timescale 1ns/100ps
`default_nettype none
module rpc_regulator_ctrl_asserts
	import rpc_pkg::*;
(
	input wire logic           core_clk,
	input wire logic           nrst,
	input wire logic           hsel,
	input wire logic [31:0]    haddr,
	input wire logic [1:0]     htrans,
	input wire logic           hwrite,
	input wire logic [31:0]    hwdata,
	input wire logic           hready,
	input wire logic [31:0]    hrdata,
	input wire logic           wake_pin,
	input wire logic           edge_wake_enable,
	input wire rpc_reset_req_t reset_req,
	input wire rpc_power_t     power,
	input wire logic           halted,
	input wire logic           edge_wake_interrupt
);
	wire logic  ap = hsel && hready && htrans[1];
	wire logic  ctl = haddr[11:0] == RPC_CTRL_ADDR;
	logic       wr_dp;
	logic [7:0] wd;
	// Data-phase copy of the last control write
	always_ff @(posedge core_clk) begin
		wr_dp <= nrst && ap && hwrite && ctl;
		if (wr_dp)
			wd <= hwdata[7:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_io_dis_write: assert property (wr_dp |-> ##[2:3] power.io_regulator_enable == !wd[7])
		else $error("io regulator enable does not follow disable bit");
	a_io_lp_write: assert property (wr_dp |-> ##[2:3] power.io_regulator_lowpower == wd[4])
		else $error("io low-power output does not follow its bit");
	a_core_lp_write: assert property (wr_dp |-> ##[2:3] power.core_regulator_lowpower == wd[1])
		else $error("core low-power output does not follow its bit");
	a_wake_level_read: assert property ($stable(wake_pin)[*4] ##0 (ap && !hwrite && ctl)
		|=> hrdata[6] == wake_pin) else $error("level bit differs from wake pin");
	a_edge_pulse: assert property (edge_wake_enable[*4] ##0 $changed(wake_pin)
		|-> ##[1:5] edge_wake_interrupt) else $error("no wake pulse after pin edge");
	a_pulse_single: assert property (edge_wake_interrupt |=> !edge_wake_interrupt)
		else $error("wake pulse longer than one cycle");
	a_running_on: assert property (!halted[*3] |-> !power.core_regulator_shutdown
		&& !power.power_net_shutdown) else $error("shutdown while running");
	a_halt_pair: assert property (halted[*3] |-> power.core_regulator_shutdown
		== power.power_net_shutdown) else $error("core and network shutdown differ");
	a_idle_rdata: assert property (!(ap && !hwrite) |=> hrdata == 32'h0)
		else $error("read data outside a read data phase");
	a_pin_reset: assert property (reset_req.pin_reset |=> !halted)
		else $error("pin reset did not leave halt");
endmodule
bind rpc_regulator_ctrl rpc_regulator_ctrl_asserts rpc_regulator_ctrl_asserts_inst (.*);
`default_nettype wire

/* test_regulator_power_control.sv */
// Self-checking bench for the regulator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module test_regulator_power_control
	import rpc_pkg::*;
;
	logic           core_clk = 0, nrst = 0, hsel = 0, hwrite = 0, wake_req = 0, wen = 0;
	logic           halt_req = 0, hreadyout, hresp, halted, ewi, irq, wake_pin;
	logic [1:0]     htrans = 0;
	logic [31:0]    haddr = 0, hwdata = 0, hrdata, rd;
	rpc_reset_req_t rst_req = '0;
	rpc_power_t     power;
	int             n_fail = 0, n_checks = 0, n_pulse = 0;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (ewi === 1'b1) n_pulse++;
	rpc_wake_src rpc_wake_src_inst (.level_req(wake_req), .wake_pin(wake_pin));
	rpc_regulator_ctrl rpc_regulator_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.wake_pin(wake_pin), .edge_wake_enable(wen), .halt_request(halt_req),
		.reset_req(rst_req), .power(power), .halted(halted), .edge_wake_interrupt(ewi), .irq(irq));
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, RPC_HTRANS_NONSEQ, wr, 20'h0, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {3'h0, d};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, exp)
	endtask
	task automatic t_ctrl;
		rdchk(RPC_CTRL_ADDR, 32'h0);
		`CHK(power, 6'h20)
		// I/O and core low-power bits set with the I/O regulator left on
		xfer(1'b1, RPC_CTRL_ADDR, 32'h12);
		tick(3);
		`CHK(power, 6'h38)
		rdchk(RPC_CTRL_ADDR, 32'h12);
		xfer(1'b1, RPC_CTRL_ADDR, 32'hc8);
		rdchk(RPC_CTRL_ADDR, 32'h88);
		`CHK(power, 6'h00)
		rdchk(12'h400, 32'h0);
		xfer(1'b1, RPC_CTRL_ADDR, 32'h0);
		tick(3);
		`CHK(power, 6'h20)
	endtask
	task automatic t_wake;
		wake_req <= 1'b1;
		tick(6);
		rdchk(RPC_CTRL_ADDR, 32'h40);
		rdchk(RPC_IRQ_STAT_ADDR, 32'h0);
		wen <= 1'b1;
		xfer(1'b1, RPC_IRQ_MASK_ADDR, 32'h3);
		wake_req <= 1'b0;
		tick(8);
		`CHK(n_pulse, 1)
		rdchk(RPC_IRQ_STAT_ADDR, 32'h2);
		`CHK(irq, 1'b1)
		xfer(1'b1, RPC_IRQ_STAT_ADDR, 32'h2);
		tick(1);
		`CHK(irq, 1'b0)
		wake_req <= 1'b1;
		tick(8);
		`CHK(n_pulse, 2)
		rdchk(RPC_IRQ_STAT_ADDR, 32'h1);
		xfer(1'b1, RPC_IRQ_MASK_ADDR, 32'h0);
		tick(1);
		`CHK(irq, 1'b0)
		xfer(1'b1, RPC_IRQ_STAT_ADDR, 32'h1);
	endtask
	task automatic pulse_halt;
		halt_req <= 1'b1;
		tick(1);
		halt_req <= 1'b0;
		tick(3);
	endtask
	task automatic t_halt;
		pulse_halt();
		`CHK(halted, 1'b1)
		`CHK(power.core_regulator_shutdown, 1'b0)
		rst_req.other_sources <= 1'b1;
		tick(1);
		rst_req.other_sources <= 1'b0;
		tick(1);
		`CHK(power.soft_reset_out, 1'b1)
		tick(2);
		`CHK(halted, 1'b0)
		xfer(1'b1, RPC_CTRL_ADDR, 32'h08);
		pulse_halt();
		`CHK(power[2:1], 2'h3)
		rst_req.other_sources <= 1'b1;
		tick(1);
		rst_req.other_sources <= 1'b0;
		tick(3);
		`CHK(halted, 1'b1)
		rst_req.pin_reset <= 1'b1;
		tick(1);
		rst_req.pin_reset <= 1'b0;
		tick(3);
		`CHK(halted, 1'b0)
		rdchk(RPC_CTRL_ADDR, 32'h40);
	endtask
	task automatic results;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		tick(16);
		nrst <= 1'b1;
		t_ctrl();
		t_wake();
		t_halt();
		results();
	end
	// Whole run is about 120 cycles; this is far beyond it
	initial begin
		#100000;
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
